// >>> fpd_divider.sv
// fpd_divider.sv: ones-complement fixed-point divide unit, restoring loop.
// assumes: instruction control and the control register file share clk;
// operands are held valid with start in the cycle the request is taken.
// a fault answers after 3 cycles, a divide after 40 or 41.
`timescale 1ns/100ps
`include "fpd_params.svh"

module fpd_divider #(
    parameter int CR_AW = `FPD_CR_AW
) (
    // clock and reset
    input  logic                clk,
    input  logic                rstn,
    // request from instruction control
    input  logic                start,
    input  fpd_pkg::fpd_op_e    op,
    input  fpd_pkg::fpd_word_t  dividend_hi,
    input  fpd_pkg::fpd_word_t  dividend_lo,
    input  fpd_pkg::fpd_word_t  divisor_word,
    input  fpd_pkg::fpd_part_e  part_sel,
    input  logic                part_sext,
    input  logic                flt_divisor,
    input  logic [CR_AW-1:0]    dest_addr,
    output logic                ready,
    // answer
    output logic                done,
    output logic                div_fault,
    // control register writes
    output logic                cr_wr_en,
    output logic [CR_AW-1:0]    cr_wr_addr,
    output fpd_pkg::fpd_word_t  cr_wr_data
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    fpd_pkg::fpd_state_e        state_q;
    fpd_pkg::fpd_state_e        state_d;
    fpd_pkg::fpd_op_e           op_q;
    fpd_pkg::fpd_op_e           op_d;
    // dividend/remainder, a magnitude from the sign step on
    fpd_pkg::fpd_dword_t        rem_q;
    fpd_pkg::fpd_dword_t        rem_d;
    // divisor magnitude; a -0 divisor turns into +0
    fpd_pkg::fpd_word_t         dsr_q;
    fpd_pkg::fpd_word_t         dsr_d;
    fpd_pkg::fpd_word_t         quo_q;
    fpd_pkg::fpd_word_t         quo_d;
    logic [`FPD_CNT_W-1:0]      cnt_q;
    logic [`FPD_CNT_W-1:0]      cnt_d;
    // result signs, taken from the operands as loaded
    logic                       qneg_q;
    logic                       qneg_d;
    logic                       rneg_q;
    logic                       rneg_d;
    // float zero is judged on the divisor as loaded
    logic                       fzero_q;
    logic                       fzero_d;
    logic [CR_AW-1:0]           dest_q;
    logic [CR_AW-1:0]           dest_d;

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    // all outputs but ready come from flip-flops
    logic                       done_q;
    logic                       done_d;
    logic                       fault_q;
    logic                       fault_d;
    logic                       wr_en_q;
    logic                       wr_en_d;
    logic [CR_AW-1:0]           wr_addr_q;
    logic [CR_AW-1:0]           wr_addr_d;
    fpd_pkg::fpd_word_t         wr_data_q;
    fpd_pkg::fpd_word_t         wr_data_d;

    // ------------------------------------------------------------------
    // datapath helpers
    // ------------------------------------------------------------------
    fpd_pkg::fpd_dword_t        ld_dividend;
    fpd_pkg::fpd_word_t         ld_divisor;
    fpd_pkg::fpd_dword_t        rem_shift;
    fpd_pkg::fpd_word_t         trial_in;
    fpd_pkg::fpd_word_t         trial_diff;
    logic                       trial_neg;
    logic                       flt_zero;
    logic                       dsr_zero;
    fpd_pkg::fpd_word_t         quo_signed;
    fpd_pkg::fpd_word_t         rem_signed;

    // ------------------------------------------------------------------
    // operand forming
    // ------------------------------------------------------------------
    fpd_operand_load u_load (
        .op           (op),
        .dividend_hi  (dividend_hi),
        .dividend_lo  (dividend_lo),
        .divisor_word (divisor_word),
        .part_sel     (part_sel),
        .part_sext    (part_sext),
        .dividend     (ld_dividend),
        .divisor      (ld_divisor)
    );

    // ------------------------------------------------------------------
    // trial subtraction
    // ------------------------------------------------------------------
    // the loop sees the shifted remainder so shift and trial share a cycle
    // outside the loop the upper word is tried unshifted
    always_comb begin
        rem_shift = {rem_q[`FPD_DWORD_W-2:0], 1'b0};
        if (state_q == fpd_pkg::fpd_st_loop) begin
            trial_in = rem_shift[`FPD_REM_HI:`FPD_REM_LO];
        end else begin
            trial_in = rem_q[`FPD_REM_HI:`FPD_REM_LO];
        end
    end

    fpd_trial_sub u_trial (
        .minuend    (trial_in),
        .subtrahend (dsr_q),
        .diff       (trial_diff),
        .neg        (trial_neg)
    );

    // ------------------------------------------------------------------
    // zero divisor detection
    // ------------------------------------------------------------------
    // a float mantissa is zero when every mantissa bit equals the sign
    always_comb begin
        flt_zero = flt_divisor &&
                   (ld_divisor[`FPD_FLT_MANT_W-1:0] ==
                    {`FPD_FLT_MANT_W{ld_divisor[`FPD_SIGN_BIT]}});
        // after the sign step both zeros read as +0
        dsr_zero = (dsr_q == '0);
    end

    // ------------------------------------------------------------------
    // result signing
    // ------------------------------------------------------------------
    // the binary point is implied only; integer and fractional quotients
    // share one bit pattern, placing the point is software's reading
    // a zero magnitude with a sign flag set comes out as -0
    always_comb begin
        if (qneg_q) begin
            quo_signed = ~quo_q;
        end else begin
            quo_signed = quo_q;
        end
        if (rneg_q) begin
            rem_signed = ~rem_q[`FPD_REM_HI:`FPD_REM_LO];
        end else begin
            rem_signed = rem_q[`FPD_REM_HI:`FPD_REM_LO];
        end
    end

    // ------------------------------------------------------------------
    // sequencer and datapath next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        op_d      = op_q;
        rem_d     = rem_q;
        dsr_d     = dsr_q;
        quo_d     = quo_q;
        cnt_d     = cnt_q;
        qneg_d    = qneg_q;
        rneg_d    = rneg_q;
        fzero_d   = fzero_q;
        dest_d    = dest_q;
        done_d    = 1'b0;
        fault_d   = 1'b0;
        wr_en_d   = 1'b0;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        case (state_q)
            fpd_pkg::fpd_st_idle: begin
                // operands are sampled on the taking edge only
                if (start) begin
                    op_d    = op;
                    rem_d   = ld_dividend;
                    dsr_d   = ld_divisor;
                    fzero_d = flt_zero;
                    dest_d  = dest_addr;
                    state_d = fpd_pkg::fpd_st_sign;
                end
            end

            // signs, then magnitudes and the pre-shift
            fpd_pkg::fpd_st_sign: begin
                qneg_d = rem_q[`FPD_DSIGN_BIT] ^
                         dsr_q[`FPD_SIGN_BIT];
                rneg_d = rem_q[`FPD_DSIGN_BIT];
                // magnitudes from here on
                if (rem_q[`FPD_DSIGN_BIT]) begin
                    rem_d = ~rem_q;
                end
                if (dsr_q[`FPD_SIGN_BIT]) begin
                    dsr_d = ~dsr_q;
                end
                quo_d = '0;
                // fractional divides keep the point between bits 35 and 34
                if (op_q == fpd_pkg::fpd_op_int) begin
                    rem_d = {rem_d[`FPD_DWORD_W-2:0], 1'b0};
                end
                state_d = fpd_pkg::fpd_st_check;
            end

            // a zero divisor never borrows, so it faults here too
            fpd_pkg::fpd_st_check: begin
                // difference discarded; only its sign is looked at
                if (!trial_neg || rem_q[`FPD_DSIGN_BIT] ||
                    dsr_zero || fzero_q) begin
                    fault_d = 1'b1;
                    done_d  = 1'b1;
                    state_d = fpd_pkg::fpd_st_idle;
                end else begin
                    cnt_d   = `FPD_ITER_CNT;
                    state_d = fpd_pkg::fpd_st_loop;
                end
            end

            // counts 35 down to 1, then on to signing
            fpd_pkg::fpd_st_loop: begin
                rem_d = rem_shift;
                quo_d = {quo_q[`FPD_WORD_W-2:0], 1'b0};
                if (!trial_neg) begin
                    rem_d[`FPD_REM_HI:`FPD_REM_LO] = trial_diff;
                    quo_d[0] = 1'b1;
                end
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == `FPD_CNT_W'(1)) begin
                    state_d = fpd_pkg::fpd_st_fix;
                end
            end

            // quotient first, remainder one address higher
            fpd_pkg::fpd_st_fix: begin
                wr_en_d   = 1'b1;
                wr_addr_d = dest_q;
                wr_data_d = quo_signed;
                state_d   = fpd_pkg::fpd_st_wr_q;
            end

            fpd_pkg::fpd_st_wr_q: begin
                if (op_q == fpd_pkg::fpd_op_sfrac) begin
                    // remainder is dropped for the single divide
                    done_d  = 1'b1;
                    state_d = fpd_pkg::fpd_st_idle;
                end else begin
                    wr_en_d   = 1'b1;
                    wr_addr_d = dest_q + 1'b1;
                    wr_data_d = rem_signed;
                    state_d   = fpd_pkg::fpd_st_wr_r;
                end
            end

            // done trails the last write by one cycle
            fpd_pkg::fpd_st_wr_r: begin
                done_d  = 1'b1;
                state_d = fpd_pkg::fpd_st_idle;
            end

            // unused state codes fall back to idle
            default: begin
                state_d = fpd_pkg::fpd_st_idle;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // datapath clears too, so no unknown reaches an output
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= fpd_pkg::fpd_st_idle;
            op_q      <= fpd_pkg::fpd_op_int;
            rem_q     <= '0;
            dsr_q     <= '0;
            quo_q     <= '0;
            cnt_q     <= '0;
            qneg_q    <= 1'b0;
            rneg_q    <= 1'b0;
            fzero_q   <= 1'b0;
            dest_q    <= '0;
            done_q    <= 1'b0;
            fault_q   <= 1'b0;
            wr_en_q   <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
        end else begin
            state_q   <= state_d;
            op_q      <= op_d;
            rem_q     <= rem_d;
            dsr_q     <= dsr_d;
            quo_q     <= quo_d;
            cnt_q     <= cnt_d;
            qneg_q    <= qneg_d;
            rneg_q    <= rneg_d;
            fzero_q   <= fzero_d;
            dest_q    <= dest_d;
            done_q    <= done_d;
            fault_q   <= fault_d;
            wr_en_q   <= wr_en_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // new requests only while idle, so one divide is in flight at a time
    // address and data hold; only the enable pulses
    assign ready      = (state_q == fpd_pkg::fpd_st_idle);
    assign done       = done_q;
    assign div_fault  = fault_q;
    assign cr_wr_en   = wr_en_q;
    assign cr_wr_addr = wr_addr_q;
    assign cr_wr_data = wr_data_q;

endmodule

// >>> fpd_params.svh
// fpd_params.svh: widths, field positions and counts for the divide unit.
// assumes: included by bare name from the divide unit files only.
`ifndef FPD_PARAMS_SVH
`define FPD_PARAMS_SVH

// ------------------------------------------------------------------
// word layout
// ------------------------------------------------------------------
`define FPD_WORD_W      36
`define FPD_DWORD_W     72
`define FPD_SIGN_BIT    35
`define FPD_DSIGN_BIT   71
`define FPD_REM_HI      71
`define FPD_REM_LO      36

// ------------------------------------------------------------------
// partial word fields of the divisor
// ------------------------------------------------------------------
`define FPD_HALF_W      18
`define FPD_THIRD_W     12

// ------------------------------------------------------------------
// floating divisor: sign over a signed mantissa in the low bits
// ------------------------------------------------------------------
`define FPD_FLT_MANT_W  27

// ------------------------------------------------------------------
// sequencing
// ------------------------------------------------------------------
`define FPD_ITER_CNT    6'h23
`define FPD_CNT_W       6
`define FPD_CR_AW       7

`endif

// >>> fpd_pkg.sv
// fpd_pkg.sv: types shared by the divide unit files.
// assumes: fpd_params.svh holds the numbers; this holds types only.
`include "fpd_params.svh"

package fpd_pkg;

    typedef logic [`FPD_WORD_W-1:0]  fpd_word_t;
    typedef logic [`FPD_DWORD_W-1:0] fpd_dword_t;

    // divide flavour chosen by instruction control
    typedef enum logic [1:0] {
        fpd_op_int,
        fpd_op_frac,
        fpd_op_sfrac
    } fpd_op_e;

    // which part of the fetched word forms the divisor
    typedef enum logic [2:0] {
        fpd_part_full,
        fpd_part_half_l,
        fpd_part_half_u,
        fpd_part_third_1,
        fpd_part_third_2,
        fpd_part_third_3
    } fpd_part_e;

    typedef enum logic [3:0] {
        fpd_st_idle,
        fpd_st_sign,
        fpd_st_check,
        fpd_st_loop,
        fpd_st_fix,
        fpd_st_wr_q,
        fpd_st_wr_r
    } fpd_state_e;

endpackage

// >>> fpd_operand_load.sv
// fpd_operand_load.sv: forms the 72-bit dividend and full-word divisor.
// assumes: operands are stable in the cycle the request is taken; purely combinational.
`timescale 1ns/100ps
`include "fpd_params.svh"

module fpd_operand_load (
    // request operands
    input  fpd_pkg::fpd_op_e   op,
    input  fpd_pkg::fpd_word_t dividend_hi,
    input  fpd_pkg::fpd_word_t dividend_lo,
    input  fpd_pkg::fpd_word_t divisor_word,
    input  fpd_pkg::fpd_part_e part_sel,
    input  logic               part_sext,
    // formed operands
    output fpd_pkg::fpd_dword_t dividend,
    output fpd_pkg::fpd_word_t  divisor
);

    logic [`FPD_HALF_W-1:0]  half_f;
    logic [`FPD_THIRD_W-1:0] third_f;

    // ------------------------------------------------------------------
    // dividend
    // ------------------------------------------------------------------
    always_comb begin
        if (op == fpd_pkg::fpd_op_sfrac) begin
            dividend = {dividend_hi,
                        {`FPD_WORD_W{dividend_hi[`FPD_SIGN_BIT]}}};
        end else begin
            dividend = {dividend_hi, dividend_lo};
        end
    end

    // ------------------------------------------------------------------
    // divisor, widened from a partial field when asked
    // ------------------------------------------------------------------
    always_comb begin
        half_f  = (part_sel == fpd_pkg::fpd_part_half_u) ?
                  divisor_word[35:18] : divisor_word[17:0];
        third_f = (part_sel == fpd_pkg::fpd_part_third_3) ? divisor_word[35:24] :
                  (part_sel == fpd_pkg::fpd_part_third_2) ? divisor_word[23:12] :
                  divisor_word[11:0];
        case (part_sel)
            fpd_pkg::fpd_part_half_l,
            fpd_pkg::fpd_part_half_u: begin
                divisor = {{`FPD_HALF_W{part_sext & half_f[`FPD_HALF_W-1]}},
                           half_f};
            end
            fpd_pkg::fpd_part_third_1,
            fpd_pkg::fpd_part_third_2,
            fpd_pkg::fpd_part_third_3: begin
                divisor = {{(`FPD_WORD_W-`FPD_THIRD_W)
                            {part_sext & third_f[`FPD_THIRD_W-1]}},
                           third_f};
            end
            default: begin
                divisor = divisor_word;
            end
        endcase
    end

endmodule

// >>> fpd_trial_sub.sv
// fpd_trial_sub.sv: trial subtraction of the divisor from a remainder word.
// assumes: both inputs are unsigned magnitudes of one word each.
`timescale 1ns/100ps
`include "fpd_params.svh"

module fpd_trial_sub (
    // magnitudes
    input  fpd_pkg::fpd_word_t minuend,
    input  fpd_pkg::fpd_word_t subtrahend,
    // result
    output fpd_pkg::fpd_word_t diff,
    output logic               neg
);

    logic [`FPD_WORD_W:0] wide;

    // one extra bit keeps the borrow, which is the sign of the difference
    always_comb begin
        wide = {1'b0, minuend} - {1'b0, subtrahend};
        diff = wide[`FPD_WORD_W-1:0];
        neg  = wide[`FPD_WORD_W];
    end

endmodule

// >>> fpd_divider_monitor.sv
// fpd_divider_monitor.sv: port timing checks for the divide unit.
// assumes: bound into fpd_divider; one clock, rstn low clears all.
`timescale 1ns/100ps

module fpd_divider_monitor #(
    parameter int CR_AW = 7
) (
    // clock and reset
    input logic               clk,
    input logic               rstn,
    // request
    input logic               start,
    input fpd_pkg::fpd_op_e   op,
    input fpd_pkg::fpd_word_t divisor_word,
    input fpd_pkg::fpd_part_e part_sel,
    input logic [CR_AW-1:0]   dest_addr,
    input logic               ready,
    // answer
    input logic               done,
    input logic               div_fault,
    input logic               cr_wr_en,
    input logic [CR_AW-1:0]   cr_wr_addr
);
    // ---
    // request tracker
    // ---
    logic             take;
    logic [5:0]       cnt_q;
    logic [5:0]       cnt_d;
    fpd_pkg::fpd_op_e op_q;
    fpd_pkg::fpd_op_e op_d;
    logic [CR_AW-1:0] dst_q;
    logic [CR_AW-1:0] dst_d;

    assign take = start && ready;

    // cycles since the request was taken, zero from the cycle after done until the next take
    always_comb begin
        cnt_d = cnt_q;
        op_d = op_q;
        dst_d = dst_q;
        if (take) begin
            cnt_d = 6'h01;
            op_d = op;
            dst_d = dest_addr;
        end else if (done) begin
            cnt_d = 6'h00;
        end else if (cnt_q != 6'h00) begin
            cnt_d = cnt_q + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 6'h00;
            op_q <= fpd_pkg::fpd_op_int;
            dst_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            op_q <= op_d;
            dst_q <= dst_d;
        end
    end

    // ---
    // checks
    // ---
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);

    fault_with_done_a: assert property (
        div_fault |-> done) else $error("fault pulse without done");
    zero_div_fault_a: assert property (
        take && part_sel == fpd_pkg::fpd_part_full &&
        (divisor_word == '0 || divisor_word == '1) |-> ##3 done && div_fault)
        else $error("zero divisor not faulted in time");
    fault_timing_a: assert property (
        done && div_fault |-> cnt_q == 6'h03 && !$past(cr_wr_en))
        else $error("fault answer late or with write");
    loop_length_a: assert property (
        done && !div_fault |->
        cnt_q == ((op_q == fpd_pkg::fpd_op_sfrac) ? 6'h28 : 6'h29))
        else $error("divide took wrong cycle count");
    single_write_a: assert property (
        done && !div_fault && op_q == fpd_pkg::fpd_op_sfrac |->
        $past(cr_wr_en) && !$past(cr_wr_en, 2) && $past(cr_wr_addr) == dst_q)
        else $error("single fractional write wrong");
    pair_write_a: assert property (
        done && !div_fault && op_q != fpd_pkg::fpd_op_sfrac |->
        $past(cr_wr_en, 2) && $past(cr_wr_en) && $past(cr_wr_addr, 2) == dst_q
        && $past(cr_wr_addr) == CR_AW'(dst_q + 1'b1))
        else $error("quotient and remainder writes wrong");
    busy_after_take_a: assert property (
        take |=> !ready) else $error("request taken but not busy");
    done_pulse_a: assert property (
        done |-> ready ##1 !done) else $error("done not a ready pulse");
    write_busy_a: assert property (
        cr_wr_en |-> !ready && cnt_q > 6'h26) else $error("write while idle");
endmodule

bind fpd_divider fpd_divider_monitor #(.CR_AW(CR_AW)) u_mon (
    .clk(clk), .rstn(rstn), .start(start), .op(op),
    .divisor_word(divisor_word), .part_sel(part_sel),
    .dest_addr(dest_addr), .ready(ready), .done(done),
    .div_fault(div_fault), .cr_wr_en(cr_wr_en), .cr_wr_addr(cr_wr_addr)
);

// >>> fpd_cr_model.sv
// fpd_cr_model.sv: control register file written by the divide unit.
// assumes: shares clk with the unit; bench reads it through rd_addr.
`timescale 1ns/100ps

module fpd_cr_model #(
    parameter int CR_AW = 7
) (
    // clock and reset
    input logic               clk,
    input logic               rstn,
    // writes from the divide unit
    input logic               wr_en,
    input logic [CR_AW-1:0]   wr_addr,
    input fpd_pkg::fpd_word_t wr_data,
    // bench read port
    input logic [CR_AW-1:0]   rd_addr,
    output fpd_pkg::fpd_word_t rd_data
);
    fpd_pkg::fpd_word_t mem_q [2**CR_AW];

    assign rd_data = mem_q[rd_addr];

    // cleared on reset so a missing or stray write shows up later
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 2**CR_AW; i++) begin
                mem_q[i] <= '0;
            end
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end
endmodule

// >>> fpd_divider_tb_top.sv
// fpd_divider_tb_top.sv: self-checking bench for the divide unit.
// assumes: fpd_cr_model stands for the register file; 100 MHz clock.
`timescale 1ns/100ps

module fpd_divider_tb_top;
    logic               clk, rstn, start, part_sext, flt_divisor;
    logic               ready, done, div_fault, cr_wr_en;
    fpd_pkg::fpd_op_e   op;
    fpd_pkg::fpd_part_e part_sel;
    fpd_pkg::fpd_word_t dividend_hi, dividend_lo, divisor_word;
    fpd_pkg::fpd_word_t cr_wr_data, rd_data;
    logic [6:0]         dest_addr, cr_wr_addr, rd_addr;
    fpd_pkg::fpd_word_t exp_mem [128];
    logic [42:0]        wq [$];
    logic               dq [$];
    int                 errors, checks_done, cycles, seed;

    fpd_divider u_dut (.clk(clk), .rstn(rstn), .start(start), .op(op),
        .dividend_hi(dividend_hi), .dividend_lo(dividend_lo),
        .divisor_word(divisor_word), .part_sel(part_sel),
        .part_sext(part_sext), .flt_divisor(flt_divisor),
        .dest_addr(dest_addr), .ready(ready), .done(done),
        .div_fault(div_fault), .cr_wr_en(cr_wr_en),
        .cr_wr_addr(cr_wr_addr), .cr_wr_data(cr_wr_data));
    fpd_cr_model u_crf (.clk(clk), .rstn(rstn), .wr_en(cr_wr_en),
        .wr_addr(cr_wr_addr), .wr_data(cr_wr_data), .rd_addr(rd_addr),
        .rd_data(rd_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic fpd_pkg::fpd_word_t rnd36();
        return 36'({$random(seed), $random(seed)});
    endfunction

    task automatic cmp(input logic [42:0] got, input logic [42:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ---
    // request driver with reference divide
    // ---
    task automatic req(input logic [1:0] o, input fpd_pkg::fpd_word_t hi,
        input fpd_pkg::fpd_word_t lo, input fpd_pkg::fpd_word_t w,
        input logic [2:0] ps, input logic sx, input logic fl,
        input logic [6:0] dst);
        logic [71:0]        dd;
        fpd_pkg::fpd_word_t dv, ds, q, m;
        logic               qn, rn, bad;
        int                 sft, fw;
        sft = (ps == 3'h2) ? 18 : (ps == 3'h4) ? 12 : (ps == 3'h5) ? 24 : 0;
        fw = (ps == 3'h0) ? 36 : (ps < 3'h3) ? 18 : 12;
        m = (fw == 36) ? '1 : ((36'h1 << fw) - 36'h1);
        dv = (w >> sft) & m;
        if (sx && dv[fw-1]) dv = dv | ~m;
        ds = dv;
        dd = (o == 2'h2) ? {hi, {36{hi[35]}}} : {hi, lo};
        qn = dd[71] ^ dv[35];
        rn = dd[71];
        if (dd[71]) dd = ~dd;
        if (dv[35]) dv = ~dv;
        if (o == 2'h0) dd = dd << 1;
        bad = dd[71:36] >= dv || dd[71] || (fl && ds[26:0] == {27{ds[35]}});
        q = '0;
        for (int i = 0; i < 35; i++) begin
            dd = dd << 1;
            q = q << 1;
            if (dd[71:36] >= dv) begin
                dd[71:36] = dd[71:36] - dv;
                q[0] = 1'b1;
            end
        end
        dq.push_back(bad);
        if (!bad) begin
            exp_mem[dst] = qn ? ~q : q;
            wq.push_back({dst, exp_mem[dst]});
            if (o != 2'h2) begin
                exp_mem[dst+7'h1] = rn ? ~dd[71:36] : dd[71:36];
                wq.push_back({dst + 7'h1, exp_mem[dst+7'h1]});
            end
        end
        // a held start while busy must be ignored, so stir the operand
        forever begin
            @(negedge clk);
            if (ready === 1'b1) break;
            dividend_hi = rnd36();
        end
        op = fpd_pkg::fpd_op_e'(o);
        dividend_hi = hi;
        dividend_lo = lo;
        divisor_word = w;
        part_sel = fpd_pkg::fpd_part_e'(ps);
        part_sext = sx;
        flt_divisor = fl;
        dest_addr = dst;
        start = 1'b1;
        @(posedge clk);
    endtask

    // ---
    // result watcher
    // ---
    always @(negedge clk) begin
        if (rstn === 1'b1 && cr_wr_en === 1'b1) begin
            cmp({cr_wr_addr, cr_wr_data}, wq.size() ? wq.pop_front() : '1);
        end
        if (rstn === 1'b1 && done === 1'b1) begin
            cmp({42'h0, div_fault}, {42'h0, dq.size() ? dq.pop_front() : 1'bx});
        end
    end

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        fpd_pkg::fpd_word_t w, hi;
        seed = 92;
        {rstn, start, part_sext, flt_divisor, dest_addr, rd_addr} = '0;
        {dividend_hi, dividend_lo, divisor_word} = '0;
        op = fpd_pkg::fpd_op_int;
        part_sel = fpd_pkg::fpd_part_full;
        foreach (exp_mem[i]) exp_mem[i] = '0;
        repeat (16) @(negedge clk);
        cmp({ready, done, div_fault, cr_wr_en}, 43'h8);
        rstn = 1'b1;
        req(2'h0, 36'h0, 36'h64, 36'h7, 3'h0, 1'b0, 1'b0, 7'h7f);
        req(2'h1, 36'h0, 36'h64, 36'h7, 3'h0, 1'b0, 1'b0, 7'h10);
        req(2'h2, ~36'h3, 36'h5, 36'h9, 3'h0, 1'b0, 1'b0, 7'h20);
        req(2'h0, '1, ~36'h64, ~36'h7, 3'h0, 1'b0, 1'b0, 7'h30);
        req(2'h1, 36'h10, 36'h0, 36'h7, 3'h0, 1'b0, 1'b0, 7'h40);
        req(2'h2, 36'h1, 36'h0, 36'h580000000, 3'h0, 1'b0, 1'b1,
            7'h0);
        req(2'h2, 36'h1, 36'h0, 36'h580000000, 3'h0, 1'b0, 1'b0,
            7'h50);
        for (int i = 0; i < 6; i++) begin
            req(2'(i % 3), 36'h1, 36'h0, (i < 3) ? 36'h0 : '1, 3'h0,
                1'b0, 1'b0, 7'h60);
        end
        for (int i = 0; i < 12; i++) begin
            req(2'h0, 36'h0, rnd36(), rnd36(), 3'(i / 2), i[0], 1'b0,
                7'(i));
        end
        repeat (60) begin
            w = rnd36();
            hi = rnd36() >> w[5:0];
            if (w[6]) hi = ~hi;
            req(2'($unsigned($random(seed)) % 3), hi, rnd36(), w, 3'h0,
                1'b0, w[7] & w[8], 7'(w[15:9]));
        end
        forever begin
            @(negedge clk);
            if (ready === 1'b1) break;
        end
        start = 1'b0;
        repeat (4) @(negedge clk);
        cmp(43'(wq.size() + dq.size()), 43'h0);
        for (int a = 0; a < 128; a++) begin
            rd_addr = 7'(a);
            #1;
            cmp({7'h0, rd_data}, {7'h0, exp_mem[a]});
        end
        complete_run();
    end
endmodule
